// *** cs_dma_pkg.sv ***
// Constants for the cycle-steal memory access controller.
// Assumes a single 200 MHz clock and a synchronous core memory port.
package cs_dma_pkg;

	localparam int WORD_W = 12;
	localparam int BANK_W = 3;
	localparam logic [11:0] WORD_ZERO = 12'h000;
	localparam logic [11:0] WORD_ONE  = 12'h001;
	localparam logic [2:0]  BANK_ZERO = 3'h0;

	// --------------------------------------------------------------
	// Sequencer states: idle, then T1..T3 of each memory cycle
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1   = 3'b001,
		ST_T2   = 3'b010,
		ST_T3   = 3'b011
	} tstate_type;

	// Which memory cycle of the transfer is running
	typedef enum logic [1:0] {
		CYC_WORD_COUNT = 2'b00,
		CYC_CUR_ADDR   = 2'b01,
		CYC_DATA       = 2'b10
	} cycle_type;

endpackage : cs_dma_pkg

// *** cs_dma.sv ***
// Cycle-steal memory access controller: one peripheral, three transfer kinds.
// Assumes the processor marks instruction boundaries and the memory answers
// reads combinationally on i_mem_rdata while o_mem_addr_r is held.
module cs_dma
	import cs_dma_pkg::*;
(
	input  wire logic              i_clk,                       // 200 MHz clock
	input  wire logic              i_sys_rst,                   // Sync reset, high
	input  wire logic              i_instr_done,                // Instruction boundary
	input  wire logic              i_break_req,                 // Peripheral request pin
	input  wire logic              i_three_cycle_select,        // Three-cycle mode pin
	input  wire logic              i_data_in_dir,               // 1: into memory
	input  wire logic              i_peripheral_mem_increment_ctl, // Increment memory word
	input  wire logic              i_current_addr_increment_ctl,  // 1: bump current address
	input  wire logic [11:0]       i_ext_addr,                  // Peripheral address
	input  wire logic [2:0]        i_ext_bank,                  // Peripheral bank bits
	input  wire logic [11:0]       i_ext_data,                  // Peripheral data
	input  wire logic [11:0]       i_mem_rdata,                 // Addressed memory word
	output logic                   o_grant_r,                   // Grant to peripheral
	output logic                   o_addr_accepted_r,           // One-cycle pulse
	output logic                   o_count_overflow_out_r,      // Word-count overflow
	output logic [11:0]            o_mem_addr_r,                // Memory address reg
	output logic [2:0]             o_break_bank_r,              // Break bank reg
	output logic [11:0]            o_buffered_store_word_out_r, // Buffered output word
	output logic                   o_mem_we_r,                  // Write strobe
	output logic [11:0]            o_mem_wdata_r,               // Write data
	output logic                   o_ir_clear_r,                // Clear instruction reg
	output logic                   o_resume_r                   // Program resumes at T1
);

	// ------------------------------------------------------------------
	// Input synchronisers for the pin inputs
	// ------------------------------------------------------------------
	// Peripheral buses must settle before the request rises; all fields
	// share the same two-stage delay, so they arrive together with it
	logic [31:0] sync1_r;
	logic [31:0] sync2_r;
	always_ff @(posedge i_clk) begin
		sync1_r <= {i_break_req, i_three_cycle_select, i_data_in_dir,
			i_peripheral_mem_increment_ctl, i_current_addr_increment_ctl,
			i_ext_bank, i_ext_addr, i_ext_data};
		sync2_r <= sync1_r;
	end
	logic        req_s, three_s, dir_in_s, minc_s, cainc_s;
	logic [2:0]  bank_s;
	logic [11:0] addr_s, data_s;
	assign req_s    = sync2_r[31];
	assign three_s  = sync2_r[30];
	assign dir_in_s = sync2_r[29];
	assign minc_s   = sync2_r[28];
	assign cainc_s  = sync2_r[27];
	assign bank_s   = sync2_r[26:24];
	assign addr_s   = sync2_r[23:12];
	assign data_s   = sync2_r[11:0];

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		tstate_type  ts;
		cycle_type   cyc;
		logic        three;
		logic        grant;
		logic        acc;
		logic        ovf;
		logic [11:0] ma;
		logic [2:0]  bank;
		logic [11:0] mb;
		logic [11:0] buffered_store_word_out;
		logic        we;
		logic [11:0] wd;
		logic        irc;
		logic        resume;
	} state_type;

	state_type st_r;
	state_type st_nxt;

	function automatic logic [12:0] inc13(input logic [11:0] w);
		inc13 = {1'b0, w} + {1'b0, WORD_ONE};
	endfunction : inc13

	// One time state of one memory cycle; used by the checks below
	function automatic logic at_step(input tstate_type ts, input cycle_type cyc,
		input tstate_type want_ts, input cycle_type want_cyc);
		at_step = (ts == want_ts) && (cyc == want_cyc);
	endfunction : at_step

	always_comb begin
		logic [12:0] sum;
		sum = inc13(i_mem_rdata);
		st_nxt = st_r;
		st_nxt.acc = 1'b0;
		st_nxt.we = 1'b0;
		st_nxt.irc = 1'b0;
		st_nxt.resume = 1'b0;
		case (st_r.ts)
			ST_IDLE: begin
				// Request sampled only at a boundary, never mid-instruction
				if (req_s && i_instr_done) begin
					st_nxt.grant = 1'b1;
					st_nxt.three = three_s;
					st_nxt.cyc = three_s ? CYC_WORD_COUNT : CYC_DATA;
					st_nxt.ts = ST_T1;
				end
			end
			ST_T1: begin
				if (st_r.cyc == CYC_CUR_ADDR) begin
					st_nxt.ma = st_r.ma + WORD_ONE;
				end else if (st_r.cyc == CYC_DATA && st_r.three) begin
					st_nxt.ma = st_r.mb;
				end else begin
					st_nxt.ma = addr_s;
					st_nxt.bank = bank_s;
					st_nxt.acc = st_r.three;
				end
				st_nxt.ts = ST_T2;
			end
			ST_T2: begin
				st_nxt.irc = 1'b1;
				st_nxt.ts = ST_T3;
			end
			ST_T3: begin
				st_nxt.ts = ST_T1;
				case (st_r.cyc)
					CYC_WORD_COUNT: begin
						st_nxt.mb = sum[11:0];
						st_nxt.we = 1'b1;
						st_nxt.wd = sum[11:0];
						st_nxt.ovf = sum[12];
						st_nxt.cyc = CYC_CUR_ADDR;
					end
					CYC_CUR_ADDR: begin
						// Peripheral may hold the address still
						st_nxt.mb = cainc_s ? sum[11:0] : i_mem_rdata;
						st_nxt.we = 1'b1;
						st_nxt.wd = cainc_s ? sum[11:0] : i_mem_rdata;
						st_nxt.cyc = CYC_DATA;
					end
					default: begin
						if (minc_s) begin
							st_nxt.mb = sum[11:0];
							st_nxt.we = 1'b1;
							st_nxt.wd = sum[11:0];
						end else if (dir_in_s) begin
							st_nxt.mb = data_s;
							st_nxt.we = 1'b1;
							st_nxt.wd = data_s;
						end else begin
							st_nxt.mb = i_mem_rdata;
							st_nxt.buffered_store_word_out = i_mem_rdata;
						end
						st_nxt.grant = 1'b0;
						st_nxt.resume = 1'b1;
						st_nxt.ts = ST_IDLE;
					end
				endcase
			end
			default: st_nxt.ts = ST_IDLE;
		endcase
		// Overflow flag lasts until the next grant starts
		if (st_r.ts == ST_IDLE && st_nxt.ts == ST_T1) begin
			st_nxt.ovf = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_grant_r = st_r.grant;
	assign o_addr_accepted_r = st_r.acc;
	assign o_count_overflow_out_r = st_r.ovf;
	assign o_mem_addr_r = st_r.ma;
	assign o_break_bank_r = st_r.bank;
	assign o_buffered_store_word_out_r = st_r.buffered_store_word_out;
	assign o_mem_we_r = st_r.we;
	assign o_mem_wdata_r = st_r.wd;
	assign o_ir_clear_r = st_r.irc;
	assign o_resume_r = st_r.resume;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	chk_grant_boundary: assert property ($rose(o_grant_r) |-> $past(i_instr_done))
		else $error("grant outside boundary");
	chk_grant_held: assert property ((st_r.ts == ST_T2) |-> o_grant_r)
		else $error("grant dropped early");
	chk_ir_clear: assert property ((st_r.ts == ST_T2) |=> o_ir_clear_r)
		else $error("no ir clear");
	chk_end_resume: assert property ($fell(o_grant_r) |-> o_resume_r)
		else $error("no resume");
	chk_ca_follow: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_WORD_COUNT)
		|=> st_r.cyc == CYC_CUR_ADDR ##3 o_mem_we_r)
		else $error("no ca cycle");
	chk_ma_inc: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T1, CYC_CUR_ADDR)
		|=> o_mem_addr_r == $past(o_mem_addr_r) + WORD_ONE)
		else $error("ma not bumped");
	chk_data_addr: assert property (
		(at_step(st_r.ts, st_r.cyc, ST_T1, CYC_DATA) && st_r.three)
		|=> o_mem_addr_r == $past(st_r.mb))
		else $error("data addr wrong");
	chk_acc_pulse: assert property (o_addr_accepted_r |=> !o_addr_accepted_r)
		else $error("accept not pulse");
	chk_wc_write: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_WORD_COUNT)
		|=> o_mem_we_r && o_mem_wdata_r == $past(i_mem_rdata) + WORD_ONE)
		else $error("wc not incremented");

	// ------------------------------------------------------------------
	// Checks: address loads and data paths
	// ------------------------------------------------------------------
	chk_single_addr: assert property (
		(st_r.ts == ST_T1 && !st_r.three)
		|=> o_mem_addr_r == $past(addr_s) && o_break_bank_r == $past(bank_s))
		else $error("single address not loaded");
	chk_wc_addr: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T1, CYC_WORD_COUNT)
		|=> o_mem_addr_r == $past(addr_s) && o_addr_accepted_r)
		else $error("word count address not loaded");
	// Bank bits only follow the pins in a cycle the peripheral addresses
	chk_three_bank: assert property (
		(st_r.ts == ST_T1 && st_r.three && st_r.cyc != CYC_WORD_COUNT)
		|=> $stable(o_break_bank_r))
		else $error("bank reloaded from pins");
	chk_in_data: assert property (
		(at_step(st_r.ts, st_r.cyc, ST_T3, CYC_DATA) && dir_in_s && !minc_s)
		|=> o_mem_we_r && o_mem_wdata_r == $past(data_s))
		else $error("inbound word not stored");
	chk_out_data: assert property (
		(at_step(st_r.ts, st_r.cyc, ST_T3, CYC_DATA) && !dir_in_s && !minc_s)
		|=> !o_mem_we_r && o_buffered_store_word_out_r == $past(i_mem_rdata))
		else $error("outbound word not shown");
	chk_mem_inc: assert property (
		(at_step(st_r.ts, st_r.cyc, ST_T3, CYC_DATA) && minc_s)
		|=> o_mem_we_r && o_mem_wdata_r == $past(i_mem_rdata) + WORD_ONE)
		else $error("memory word not incremented");
	chk_ca_write: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_CUR_ADDR)
		|=> o_mem_we_r && o_mem_wdata_r == $past(i_mem_rdata) + {11'h000, $past(cainc_s)})
		else $error("current address write back wrong");

	// ------------------------------------------------------------------
	// Checks: sequencing and flags
	// ------------------------------------------------------------------
	chk_data_follow: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_CUR_ADDR)
		|=> st_r.ts == ST_T1 && st_r.cyc == CYC_DATA)
		else $error("data cycle not entered");
	chk_end_t3: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_DATA)
		|=> !o_grant_r && o_resume_r && st_r.ts == ST_IDLE)
		else $error("transfer did not end");
	chk_grant_span: assert property (
		o_grant_r == (st_r.ts != ST_IDLE))
		else $error("grant does not match busy");
	chk_ovf_set: assert property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_WORD_COUNT)
		|=> o_count_overflow_out_r == (&$past(i_mem_rdata)))
		else $error("overflow flag wrong");
	// Flag must survive idle time so a slow peripheral still sees it
	chk_ovf_hold: assert property (
		(o_count_overflow_out_r && !o_grant_r)
		|=> o_count_overflow_out_r || o_grant_r)
		else $error("overflow lost while idle");
	chk_ir_pulse: assert property (o_ir_clear_r |=> !o_ir_clear_r)
		else $error("ir clear not pulse");
	chk_resume_pulse: assert property (o_resume_r |=> !o_resume_r)
		else $error("resume not pulse");
	chk_acc_three: assert property (o_addr_accepted_r |-> st_r.three)
		else $error("accept outside three cycle");

	// ------------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------------
	cov_single: cover property ($rose(o_grant_r) && !st_r.three);
	cov_three: cover property ($rose(o_grant_r) && st_r.three);
	cov_ovf: cover property ($rose(o_count_overflow_out_r));
	cov_mem_inc: cover property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_DATA) && minc_s);
	cov_ca_hold: cover property (
		at_step(st_r.ts, st_r.cyc, ST_T3, CYC_CUR_ADDR) && !cainc_s);

endmodule : cs_dma

// *** cs_dma_peripheral.sv ***
// Peripheral model for the cycle-steal controller: request flag only.
// Assumes the bench sets the transfer controls before pulsing i_go.
module cs_dma_peripheral (
	input  wire logic i_clk,   // Bench clock
	input  wire logic i_sys_rst, // Sync reset
	input  wire logic i_go,    // Bench asks for one transfer
	input  wire logic i_grant, // Grant from controller
	output logic      o_req    // Request to controller
);
	timeunit 1ns;
	timeprecision 100ps;
	logic seen_r;

	// Single requester on the port; no multiplexer needed
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_req  <= 1'b0;
			seen_r <= 1'b0;
		end else if (i_go) begin
			o_req <= 1'b1;
		end else if (seen_r && !i_grant) begin
			o_req  <= 1'b0;
			seen_r <= 1'b0;
		end else if (i_grant) begin
			seen_r <= 1'b1;
		end
	end
endmodule : cs_dma_peripheral

// *** cs_dma_bench.sv ***
// Self-checking bench for the cycle-steal controller.
// Assumes a behavioural core memory with combinational read.
module cs_dma_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import cs_dma_pkg::*;
	logic clk = 0, rst = 1, done = 0, go = 0, req, three = 0, dir = 0, minc = 0, cainc = 0;
	logic [11:0] ea = 0, ed = 0, maddr, wdata, buffered_store_word_out;
	logic [2:0]  eb = 0, bank;
	logic        grant, acc, ovf, we, irc, res;
	logic [11:0] mem [4096];
	int          failures = 0, checks = 0;

	initial forever #2.5 clk = ~clk;
	always @(posedge clk) if (we) mem[maddr] <= wdata;

	cs_dma dut (.i_clk(clk), .i_sys_rst(rst), .i_instr_done(done), .i_break_req(req),
		.i_three_cycle_select(three), .i_data_in_dir(dir),
		.i_peripheral_mem_increment_ctl(minc), .i_current_addr_increment_ctl(cainc),
		.i_ext_addr(ea), .i_ext_bank(eb), .i_ext_data(ed), .i_mem_rdata(mem[maddr]),
		.o_grant_r(grant), .o_addr_accepted_r(acc), .o_count_overflow_out_r(ovf),
		.o_mem_addr_r(maddr), .o_break_bank_r(bank), .o_buffered_store_word_out_r(buffered_store_word_out),
		.o_mem_we_r(we), .o_mem_wdata_r(wdata), .o_ir_clear_r(irc), .o_resume_r(res));
	cs_dma_peripheral peri (.i_clk(clk), .i_sys_rst(rst), .i_go(go), .i_grant(grant),
		.o_req(req));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task check(input logic [11:0] s, input logic [11:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, s, e);
		end
	endtask : check

	task complete_run;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// Holds the boundary low first so an early grant shows up
	task run(input logic t, d, mi, ci, input logic [11:0] a, x);
		int n, k, p;
		three = t; dir = d; minc = mi; cainc = ci; ea = a; ed = x; eb = 3'h5;
		done = 0; go = 1; n = 0; k = 0; p = 0;
		@(posedge clk);
		#1 go = 0;
		repeat (8) begin
			@(posedge clk);
			#1 check({11'h0, grant}, 12'h000);
		end
		done = 1;
		while (grant !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		if (grant !== 1'b1) begin
			failures++;
			complete_run;
		end
		// Boundary dropped so the lingering request is not served twice
		done = 0; n = 0;
		while (grant === 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
			k += irc;
			p += acc;
		end
		if (n >= 20) begin
			failures++;
			complete_run;
		end
		check(12'(n), t ? 12'h009 : 12'h003);
		check({11'h0, res}, 12'h001);
		check(12'(k), t ? 12'h003 : 12'h001);
		check(12'(p), t ? 12'h001 : 12'h000);
		check({9'h0, bank}, 12'h005);
		repeat (4) @(posedge clk);
		#1 $display("test done");
	endtask : run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		#1 rst = 0;
		run(0, 1, 0, 0, 12'h123, 12'habc);
		check(mem[12'h123], 12'habc);
		mem[12'h200] = 12'h5a5;
		run(0, 0, 0, 0, 12'h200, 12'h0ff);
		check(buffered_store_word_out, 12'h5a5);
		check(mem[12'h200], 12'h5a5);
		mem[12'h300] = 12'hfff;
		run(0, 1, 1, 0, 12'h300, 12'h111);
		check(mem[12'h300], 12'h000);
		mem[12'h040] = 12'hfff;
		mem[12'h041] = 12'h3ff;
		run(1, 1, 0, 1, 12'h040, 12'h777);
		check(mem[12'h040], 12'h000);
		check({11'h0, ovf}, 12'h001);
		check(mem[12'h041], 12'h400);
		check(mem[12'h400], 12'h777);
		mem[12'h040] = 12'hffe;
		mem[12'h041] = 12'h500;
		mem[12'h500] = 12'h2c3;
		run(1, 0, 0, 0, 12'h040, 12'h0ff);
		check(mem[12'h040], 12'hfff);
		check({11'h0, ovf}, 12'h000);
		check(mem[12'h041], 12'h500);
		check(buffered_store_word_out, 12'h2c3);
		complete_run;
	end
endmodule : cs_dma_bench
